// ### hw/dls_pkg.sv
// Constants for the decoder learn, erase, output action and serial report block.
// Assumes a 200 MHz core clock; all timing counts derive from it.
package dls_pkg;
   localparam int unsigned CLK_HZ             = 200_000_000;
   localparam int unsigned BAUD_RATE          = 9_600;
   localparam int unsigned BIT_CYCLES         = CLK_HZ / BAUD_RATE;
   localparam int unsigned CONFIRM_WINDOW_S   = 10;
   localparam int unsigned CONFIRM_CYCLES     = CONFIRM_WINDOW_S * CLK_HZ;
   localparam int unsigned ERASE_HOLD_S       = 8;
   localparam int unsigned ERASE_HOLD_CYCLES  = ERASE_HOLD_S * CLK_HZ;
   localparam int unsigned REPEAT_MS          = 500;
   localparam int unsigned REPEAT_CYCLES      = REPEAT_MS * (CLK_HZ / 1000);
   localparam int unsigned FLASH_MS           = 250;
   localparam int unsigned FLASH_CYCLES       = FLASH_MS * (CLK_HZ / 1000);
   localparam int unsigned NUM_OUTPUTS        = 3;
   localparam int unsigned MAX_PAIRINGS       = 15;
   localparam int unsigned REPORT_BYTES       = 7;
   localparam int unsigned FRAME_BITS         = 10;
   localparam logic [7:0]  CR_BYTE            = 8'h0D;
   localparam logic [7:0]  LF_BYTE            = 8'h0A;
   localparam int unsigned STAT_LEARNT_BIT    = 1;
   localparam int unsigned STAT_BATT_BIT      = 0;
   localparam logic [2:0]  OUTPUTS_IDLE       = 3'h7;
endpackage

// ### hw/dls_decoder.sv
// Holds all control logic and the pairing table in flip-flops.
// Assumes a front end delivers one-cycle packet strobes with decoded fields.
`timescale 1ns/1ps
module dls_decoder #(
   parameter int unsigned CONFIRM_CYCLES    = dls_pkg::CONFIRM_CYCLES,
   parameter int unsigned ERASE_HOLD_CYCLES = dls_pkg::ERASE_HOLD_CYCLES,
   parameter int unsigned REPEAT_CYCLES     = dls_pkg::REPEAT_CYCLES,
   parameter int unsigned FLASH_CYCLES      = dls_pkg::FLASH_CYCLES,
   parameter int unsigned BIT_CYCLES        = dls_pkg::BIT_CYCLES,
   parameter int unsigned ENC_INPUTS        = 3
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        learn_pushbutton_b,
   input  wire logic        output_action_option_input_b,
   input  wire logic        packet_valid,
   input  wire logic [15:0] encoder_serial_field,
   input  wire logic [15:0] encoder_input_field,
   input  wire logic        encoder_battery_low,
   output logic             learn_led,
   output logic             erase_busy,
   output logic             erase_done,
   output logic             serial_report_out,
   output logic [2:0]       decoded_output_b
);
   localparam int unsigned NP = dls_pkg::MAX_PAIRINGS;
   typedef enum logic [2:0] {DLS_IDLE, DLS_FLASH, DLS_SELECT, DLS_WAIT_FIRST, DLS_WAIT_CONFIRM,
                             DLS_DONE_FLASH, DLS_ERASE} dls_learn_t;
   ////////////////////////////////////////////////////////////////////////////
   // Learn pin edge and hold timing
   logic        learn_q, press_rel, erase_req;
   logic [31:0] hold_cnt;
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         learn_q  <= 1'b1;
         hold_cnt <= 32'h0000_0000;
      end
      else
      begin
         learn_q <= learn_pushbutton_b;
         if (!learn_pushbutton_b && hold_cnt < ERASE_HOLD_CYCLES)
            hold_cnt <= hold_cnt + 32'h0000_0001;
         else if (learn_pushbutton_b)
            hold_cnt <= 32'h0000_0000;
      end
   end
   // A release counts as a brief press only if erase did not trigger
   assign press_rel = learn_pushbutton_b && !learn_q && (hold_cnt < ERASE_HOLD_CYCLES);
   assign erase_req = !learn_pushbutton_b && (hold_cnt == ERASE_HOLD_CYCLES - 1);
   ////////////////////////////////////////////////////////////////////////////
   // Pairing table
   logic [NP-1:0] pair_used;
   logic [15:0]   pair_serial [NP], pair_input [NP];
   logic [1:0]    pair_chan   [NP];
   // Called from a process: an assign would miss table updates while the fields stay put
   function automatic logic [NP-1:0] match_vec(input logic [15:0] ser, input logic [15:0] inp);
      match_vec = '0;
      for (int i = 0; i < NP; i++)
         match_vec[i] = pair_used[i] && pair_serial[i] == ser && (pair_input[i] & inp) != 16'h0000;
   endfunction
   logic [NP-1:0] hit;
   logic [3:0]    free_idx;
   logic          free_ok;
   always_comb
   begin
      hit      = match_vec(encoder_serial_field, encoder_input_field);
      free_idx = 4'h0;
      free_ok  = !(&pair_used);
      for (int i = NP - 1; i >= 0; i--)
         if (!pair_used[i])
            free_idx = 4'(i);
   end
   ////////////////////////////////////////////////////////////////////////////
   // Learn and erase controller
   dls_learn_t  lstate;
   logic [1:0]  sel_chan;
   logic [31:0] tmr;
   logic [15:0] cand_serial, cand_input;
   logic        store_now;
   assign store_now = (lstate == DLS_WAIT_CONFIRM) && packet_valid && encoder_serial_field == cand_serial
                      && encoder_input_field == cand_input;
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lstate      <= DLS_IDLE;
         sel_chan    <= 2'h0;
         tmr         <= 32'h0000_0000;
         cand_serial <= 16'h0000;
         cand_input  <= 16'h0000;
         learn_led   <= 1'b0;
         erase_busy  <= 1'b0;
         erase_done  <= 1'b0;
      end
      else
      begin
         erase_done <= 1'b0;
         if (erase_req)
         begin
            lstate     <= DLS_ERASE;
            learn_led  <= 1'b1;
            erase_busy <= 1'b1;
         end
         else
            case (lstate)
               DLS_IDLE:
                  if (press_rel)
                  begin
                     sel_chan  <= 2'h0;
                     lstate    <= DLS_FLASH;
                     learn_led <= 1'b1;
                     tmr       <= 32'h0000_0000;
                  end
               DLS_FLASH, DLS_DONE_FLASH:
                  if (tmr >= FLASH_CYCLES - 1)
                  begin
                     learn_led <= 1'b0;
                     lstate    <= (lstate == DLS_FLASH) ? DLS_SELECT : DLS_IDLE;
                  end
                  else
                     tmr <= tmr + 32'h0000_0001;
               DLS_SELECT:
                  if (press_rel)
                  begin
                     sel_chan  <= (sel_chan == 2'(dls_pkg::NUM_OUTPUTS - 1)) ? 2'h0 : sel_chan + 2'h1;
                     lstate    <= DLS_FLASH;
                     learn_led <= 1'b1;
                     tmr       <= 32'h0000_0000;
                  end
                  else if (packet_valid && encoder_input_field != 16'h0000)
                  begin
                     cand_serial <= encoder_serial_field;
                     cand_input  <= encoder_input_field;
                     learn_led   <= 1'b1;
                     tmr         <= 32'h0000_0000;
                     lstate      <= DLS_WAIT_FIRST;
                  end
               DLS_WAIT_FIRST:
                  // Ignore the rest of the first burst until the encoder goes quiet
                  if (tmr >= REPEAT_CYCLES)
                  begin
                     tmr    <= 32'h0000_0000;
                     lstate <= DLS_WAIT_CONFIRM;
                  end
                  else if (packet_valid)
                     tmr <= 32'h0000_0000;
                  else
                     tmr <= tmr + 32'h0000_0001;
               DLS_WAIT_CONFIRM:
                  if (store_now)
                  begin
                     tmr       <= 32'h0000_0000;
                     lstate    <= DLS_DONE_FLASH;
                  end
                  else if (tmr >= CONFIRM_CYCLES - 1)
                  begin
                     learn_led <= 1'b0;
                     lstate    <= DLS_IDLE;
                  end
                  else
                     tmr <= tmr + 32'h0000_0001;
               DLS_ERASE:
               begin
                  learn_led  <= 1'b0;
                  erase_busy <= 1'b0;
                  erase_done <= 1'b1;
                  lstate     <= DLS_IDLE;
               end
               default:
                  lstate <= DLS_IDLE;
            endcase
      end
   end
   generate
      for (genvar g = 0; g < NP; g++)
      begin : g_pair
         always_ff @(posedge core_clk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               pair_used[g]   <= 1'b0;
               pair_serial[g] <= 16'h0000;
               pair_input[g]  <= 16'h0000;
               pair_chan[g]   <= 2'h0;
            end
            else if (lstate == DLS_ERASE)
               pair_used[g] <= 1'b0;
            else if (store_now && free_ok && free_idx == 4'(g))
            begin
               pair_used[g]   <= 1'b1;
               pair_serial[g] <= cand_serial;
               pair_input[g]  <= cand_input;
               pair_chan[g]   <= sel_chan;
            end
         end
      end
   endgenerate
   ////////////////////////////////////////////////////////////////////////////
   // Outputs, latching or momentary
   logic        mode_latch, opt_taken, rx_active;
   logic [2:0]  active_now;
   logic [31:0] quiet_cnt;
   always_comb
   begin
      active_now = 3'h0;
      for (int i = 0; i < NP; i++)
         if (hit[i])
            active_now[pair_chan[i]] = 1'b1;
   end
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mode_latch <= 1'b1;
         opt_taken  <= 1'b0;
      end
      else if (!opt_taken)
      begin
         mode_latch <= output_action_option_input_b;
         opt_taken  <= 1'b1;
      end
   end
   // Session ends when no packet arrives for one repeat period
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rx_active        <= 1'b0;
         quiet_cnt        <= 32'h0000_0000;
         decoded_output_b <= dls_pkg::OUTPUTS_IDLE;
      end
      else if (packet_valid)
      begin
         rx_active <= 1'b1;
         quiet_cnt <= 32'h0000_0000;
         if (mode_latch && !rx_active)
            decoded_output_b <= decoded_output_b ^ active_now;
         else if (!mode_latch)
            decoded_output_b <= decoded_output_b & ~active_now;
      end
      else if (quiet_cnt >= REPEAT_CYCLES)
      begin
         rx_active <= 1'b0;
         if (!mode_latch)
            decoded_output_b <= dls_pkg::OUTPUTS_IDLE;
      end
      else
         quiet_cnt <= quiet_cnt + 32'h0000_0001;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Serial report
   logic [7:0]  rpt [dls_pkg::REPORT_BYTES];
   logic [31:0] rep_cnt;
   logic        send_req, tx_busy;
   logic [2:0]  byte_idx;
   logic [3:0]  bit_idx;
   logic [15:0] baud_cnt, in_mask;
   logic [9:0]  shreg;
   assign in_mask = 16'((32'h1 << ENC_INPUTS) - 32'h1);
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rep_cnt  <= 32'h0000_0000;
         send_req <= 1'b0;
         for (int i = 0; i < dls_pkg::REPORT_BYTES; i++)
            rpt[i] <= 8'h00;
      end
      else
      begin
         if (tx_busy)
            send_req <= 1'b0;
         if (packet_valid)
         begin
            // First packet of a session or half-second repeat while data keeps arriving
            if (!rx_active || rep_cnt >= REPEAT_CYCLES - 1)
            begin
               send_req <= !tx_busy;
               rep_cnt  <= 32'h0000_0000;
               rpt[0] <= encoder_serial_field[15:8];
               rpt[1] <= encoder_serial_field[7:0];
               rpt[2] <= encoder_input_field[15:8] & in_mask[15:8];
               rpt[3] <= encoder_input_field[7:0] & in_mask[7:0];
               rpt[4] <= {6'h00, |hit, encoder_battery_low};
               rpt[5] <= dls_pkg::CR_BYTE;
               rpt[6] <= dls_pkg::LF_BYTE;
            end
            else
               rep_cnt <= rep_cnt + 32'h0000_0001;
         end
         else if (rx_active)
            rep_cnt <= rep_cnt + 32'h0000_0001;
      end
   end
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tx_busy           <= 1'b0;
         byte_idx          <= 3'h0;
         bit_idx           <= 4'h0;
         baud_cnt          <= 16'h0000;
         shreg             <= 10'h3FF;
         serial_report_out <= 1'b1;
      end
      else if (!tx_busy)
      begin
         serial_report_out <= 1'b1;
         if (send_req)
         begin
            tx_busy  <= 1'b1;
            byte_idx <= 3'h0;
            bit_idx  <= 4'h0;
            baud_cnt <= 16'h0000;
            shreg    <= {1'b1, rpt[0], 1'b0};
         end
      end
      else if (baud_cnt == 16'(BIT_CYCLES - 1))
      begin
         baud_cnt <= 16'h0000;
         if (bit_idx == 4'(dls_pkg::FRAME_BITS - 1))
         begin
            bit_idx <= 4'h0;
            if (byte_idx == 3'(dls_pkg::REPORT_BYTES - 1))
               tx_busy <= 1'b0;
            else
            begin
               byte_idx <= byte_idx + 3'h1;
               shreg    <= {1'b1, rpt[byte_idx + 3'h1], 1'b0};
            end
         end
         else
         begin
            bit_idx <= bit_idx + 4'h1;
            shreg   <= {1'b1, shreg[9:1]};
         end
      end
      else
      begin
         baud_cnt          <= baud_cnt + 16'h0001;
         serial_report_out <= shreg[0];
      end
   end
endmodule

// ### verif/dls_decoder_assertions.sv
// Checker for the decoder learn, erase and report block.
// Assumes it is bound to dls_decoder and sees only its ports.
`timescale 1ns/1ps
module dls_decoder_assertions #(
   parameter int unsigned ERASE_HOLD_CYCLES = dls_pkg::ERASE_HOLD_CYCLES,
   parameter int unsigned REPEAT_CYCLES     = dls_pkg::REPEAT_CYCLES,
   parameter int unsigned BIT_CYCLES        = dls_pkg::BIT_CYCLES
) (
   input wire logic       core_clk,
   input wire logic       rst_b,
   input wire logic       learn_pushbutton_b,
   input wire logic       output_action_option_input_b,
   input wire logic       packet_valid,
   input wire logic       learn_led,
   input wire logic       erase_busy,
   input wire logic       erase_done,
   input wire logic       serial_report_out,
   input wire logic [2:0] decoded_output_b
);
   // Long enough for the last report to drain and the session to end
   localparam int QUIET = BIT_CYCLES * 70 + REPEAT_CYCLES + 10;
   int   low_cnt;
   int   gap;
   int   run;
   logic prev;
   logic first_q;
   logic mom_q;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
////////////////////
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         low_cnt <= 0;
         gap     <= QUIET;
         run     <= 0;
         prev    <= 1'b1;
         first_q <= 1'b1;
         mom_q   <= 1'b0;
      end
      else
      begin
         low_cnt <= learn_pushbutton_b ? 0 : low_cnt + 1;
         gap     <= packet_valid ? 0 : (gap < QUIET ? gap + 1 : gap);
         run     <= (serial_report_out != prev) ? 1 : run + 1;
         prev    <= serial_report_out;
         first_q <= 1'b0;
         if (first_q)
            mom_q <= !output_action_option_input_b;
      end
   end
////////////////////
   erase_led_on_a: assert property (erase_busy |-> learn_led)
      else $error("led dark during erase");
   busy_then_done_a: assert property (erase_busy |=> erase_done && !erase_busy && !learn_led)
      else $error("erase did not complete");
   done_one_cycle_a: assert property (erase_done |=> !erase_done)
      else $error("erase done too long");
   done_cause_a: assert property (erase_done |-> $past(erase_busy))
      else $error("erase done without erase");
   erase_hold_time_a: assert property ($rose(erase_busy) |->
      low_cnt >= ERASE_HOLD_CYCLES - 3 && low_cnt <= ERASE_HOLD_CYCLES + 1)
      else $error("erase at wrong hold time");
   report_start_a: assert property (packet_valid && gap == QUIET |-> ##[1:4] !serial_report_out)
      else $error("no report after packet");
   bit_width_a: assert property ($rose(serial_report_out) |->
      run % BIT_CYCLES == 0 && run <= 9 * BIT_CYCLES)
      else $error("bad low run on serial line");
   output_cause_a: assert property (|($past(decoded_output_b) & ~decoded_output_b) |->
      $past(packet_valid) || $past(packet_valid, 2))
      else $error("output asserted without packet");
   momentary_release_a: assert property (mom_q && gap > REPEAT_CYCLES + 4 |-> decoded_output_b == 3'h7)
      else $error("momentary output held");
endmodule

bind dls_decoder dls_decoder_assertions #(
   .ERASE_HOLD_CYCLES(ERASE_HOLD_CYCLES),
   .REPEAT_CYCLES    (REPEAT_CYCLES),
   .BIT_CYCLES       (BIT_CYCLES)
) dls_decoder_assertions_inst (.core_clk, .rst_b, .learn_pushbutton_b, .output_action_option_input_b,
   .packet_valid, .learn_led, .erase_busy, .erase_done, .serial_report_out, .decoded_output_b);

// ### verif/dls_report_rx.sv
// Receiver model of the host reading serial reports.
// Assumes the line idles high and bits last BIT_CYCLES clocks.
`timescale 1ns/1ps
module dls_report_rx #(
   parameter int unsigned BIT_CYCLES = 4
) (
   input wire logic  core_clk,
   input wire logic  tx_line,
   output logic [7:0] rx_byte,
   output logic       rx_stb,
   output logic       frame_err
);
   initial
   begin
      rx_byte   = 8'h00;
      rx_stb    = 1'b0;
      frame_err = 1'b0;
      forever
      begin
         @(negedge tx_line);
         // Sample mid bit so one cycle of skew is tolerated
         repeat (BIT_CYCLES / 2) @(posedge core_clk);
         for (int i = 0; i < 8; i++)
         begin
            repeat (BIT_CYCLES) @(posedge core_clk);
            rx_byte[i] <= tx_line;
         end
         repeat (BIT_CYCLES) @(posedge core_clk);
         if (tx_line !== 1'b1)
            frame_err <= 1'b1;
         rx_stb <= 1'b1;
         @(posedge core_clk);
         rx_stb <= 1'b0;
      end
   end
endmodule

// ### verif/test_dls_decoder.sv
// Self-checking bench for the decoder learn, erase and report block.
// Assumes shortened counts; the report model decodes the serial line.
`timescale 1ns/1ps
module test_dls_decoder;
   localparam int FL = 50;
   localparam int RP = 500;
   logic        core_clk;
   logic        rst_b;
   logic        btn_b;
   logic        opt_b;
   logic        pv;
   logic [15:0] ser;
   logic [15:0] inp;
   logic        bat;
   logic        led;
   logic        busy;
   logic        done;
   logic        tx;
   logic [2:0]  out_b;
   logic [7:0]  rx_byte;
   logic        rx_stb;
   logic        ferr;
   logic [7:0]  q[$];
   int          bad_count;
   int          comparisons;
   int          cyc;
   dls_decoder #(.CONFIRM_CYCLES(2000), .ERASE_HOLD_CYCLES(1000), .REPEAT_CYCLES(RP),
      .FLASH_CYCLES(FL), .BIT_CYCLES(4)) dls_decoder_inst (.core_clk(core_clk), .rst_b(rst_b),
      .learn_pushbutton_b(btn_b), .output_action_option_input_b(opt_b), .packet_valid(pv),
      .encoder_serial_field(ser), .encoder_input_field(inp), .encoder_battery_low(bat),
      .learn_led(led), .erase_busy(busy), .erase_done(done), .serial_report_out(tx),
      .decoded_output_b(out_b));
   dls_report_rx #(.BIT_CYCLES(4)) dls_report_rx_inst (.core_clk(core_clk), .tx_line(tx),
      .rx_byte(rx_byte), .rx_stb(rx_stb), .frame_err(ferr));
////////////////////
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      if (rx_stb)
         q.push_back(rx_byte);
      cyc++;
      // Whole run needs about 13300 cycles
      if (cyc == 20000)
      begin
         bad_count++;
         end_sim();
      end
   end
////////////////////
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic send(input logic [15:0] s, input logic [15:0] i, input logic b);
      pv  <= 1'b1;
      ser <= s;
      inp <= i;
      bat <= b;
      idle(1);
      pv  <= 1'b0;
      idle(1);
   endtask
   task automatic press(input int n);
      btn_b <= 1'b0;
      idle(n);
      btn_b <= 1'b1;
      idle(1);
   endtask
   task automatic rpt(input logic [15:0] s, input logic [7:0] ih, input logic [7:0] il, input logic [7:0] st);
      for (int w = 0; w < 400 && q.size() < 7; w++)
         idle(1);
      chk(16'(q.size()), 16'h0007);
      chk(q[0], s[15:8]);
      chk(q[1], s[7:0]);
      chk(q[2], ih);
      chk(q[3], il);
      chk(q[4], st);
      chk(q[5], 8'h0D);
      chk(q[6], 8'h0A);
      q.delete();
   endtask
   task automatic do_learn(input int n, input logic [15:0] s, input logic [15:0] i);
      for (int k = 0; k < n; k++)
      begin
         press(5);
         idle(2);
         chk(led, 1'b1);
         idle(FL + 5);
         chk(led, 1'b0);
      end
      send(s, i, 1'b0);
      idle(3);
      chk(led, 1'b1);
      idle(RP + 50);
      chk(led, 1'b1);
      send(s, i, 1'b0);
      idle(FL + 5);
      chk(led, 1'b0);
      idle(RP + 300);
      q.delete();
   endtask
////////////////////
   task automatic t_report();
      send(16'h12AB, 16'h8105, 1'b1);
      rpt(16'h12AB, 8'h00, 8'h05, 8'h01);
      idle(RP);
   endtask
   task automatic t_repeat();
      for (int i = 0; i < 110; i++)
      begin
         send(16'h5A3C, 16'h0001, 1'b0);
         idle(8);
      end
      idle(400);
      chk(16'(q.size()), 16'h0015);
      q.delete();
      idle(RP);
   endtask
   task automatic t_learn();
      do_learn(2, 16'hC3E1, 16'h0002);
      send(16'hC3E1, 16'h0002, 1'b0);
      idle(2);
      chk(out_b, 3'b101);
      rpt(16'hC3E1, 8'h00, 8'h02, 8'h02);
      idle(RP + 50);
      send(16'hC3E1, 16'h0002, 1'b0);
      idle(2);
      chk(out_b, 3'h7);
      idle(RP + 300);
      q.delete();
   endtask
   task automatic t_erase();
      btn_b <= 1'b0;
      for (int w = 0; w < 1200 && busy !== 1'b1; w++)
         idle(1);
      chk(busy, 1'b1);
      chk(led, 1'b1);
      idle(1);
      chk(done, 1'b1);
      chk(led, 1'b0);
      btn_b <= 1'b1;
      idle(FL + 10);
      chk(led, 1'b0);
      send(16'hC3E1, 16'h0002, 1'b0);
      idle(2);
      chk(out_b, 3'h7);
      rpt(16'hC3E1, 8'h00, 8'h02, 8'h00);
      idle(RP);
   endtask
   task automatic t_timeout();
      press(5);
      idle(FL + 5);
      send(16'h7E01, 16'h0004, 1'b0);
      idle(RP + 1500);
      chk(led, 1'b1);
      idle(600);
      chk(led, 1'b0);
      send(16'h7E01, 16'h0004, 1'b0);
      idle(2);
      chk(led, 1'b0);
      chk(out_b, 3'h7);
      idle(RP + 300);
      q.delete();
   endtask
   task automatic t_moment();
      rst_b <= 1'b0;
      opt_b <= 1'b0;
      idle(4);
      rst_b <= 1'b1;
      idle(3);
      do_learn(1, 16'h0F0F, 16'h0001);
      send(16'h0F0F, 16'h0001, 1'b0);
      idle(2);
      chk(out_b, 3'b110);
      send(16'h0F0F, 16'h0001, 1'b0);
      idle(2);
      chk(out_b, 3'b110);
      idle(RP + 20);
      chk(out_b, 3'h7);
   endtask
////////////////////
   initial
   begin
      bad_count   = 0;
      comparisons = 0;
      cyc         = 0;
      rst_b = 1'b0;
      btn_b = 1'b1;
      opt_b = 1'b1;
      pv    = 1'b0;
      ser   = 16'h0000;
      inp   = 16'h0000;
      bat   = 1'b0;
      idle(4);
      rst_b <= 1'b1;
      idle(3);
      t_report();
      t_repeat();
      t_learn();
      t_erase();
      t_timeout();
      t_moment();
      chk(ferr, 1'b0);
      end_sim();
   end
endmodule
